// File: hdl/vcp_builder.sv
`timescale 1ns/10ps
module vcp_builder #(
	parameter logic [63:0] PS_PER_SEC    = vcp_pkg::VCP_PS_PER_SEC,
	parameter logic [31:0] DIG_STREAM_ID = vcp_pkg::VCP_DIG_SID_DEF
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic [vcp_pkg::VCP_ADDR_W-1:0] paddr,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [31:0]                  pwdata,
	output logic [31:0]                       prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic [15:0]                  rfe_gain,
	output logic [31:0]                       tx_data,
	output logic                              tx_valid,
	output logic                              tx_last,
	input  wire logic                         tx_ready
);
	import vcp_pkg::*;

	vcp_state_t  state_reg;
	logic        wr_go;
	logic        rd_err;
	logic [31:0] rd_data;
	logic        start;
	logic        sel_dig;
	vcp_time_t   now;

	// Software visible configuration, plus the last sampled front-end gain
	vcp_fix64_t  bw_reg;
	vcp_fix64_t  fo_reg;
	logic [15:0] ref_nom_reg;
	logic [31:0] stream_id_reg;
	logic [31:0] sweep_id_reg;
	logic        channel_swap_flag;
	logic [15:0] gain_prev_reg;

	// Requests and pending-change flags
	logic        req_dig_reg;
	logic        req_ext_reg;
	logic        pend_bw_reg;
	logic        pend_fo_reg;
	logic        pend_rl_reg;
	logic        pend_swap_reg;
	logic        stream_start_flag;
	logic        sweep_start_flag;

	// Packet assembly
	logic [3:0]  dig_cnt_reg;
	logic [3:0]  ext_cnt_reg;
	logic [3:0]  idx_reg;
	logic [3:0]  len_reg;
	logic [3:0]  build_len;
	logic [31:0] build_words [VCP_MAX_WORDS];
	logic [31:0] pkt_mem     [VCP_MAX_WORDS];
	logic [31:0] bw_hi;
	logic [31:0] bw_lo;
	logic [31:0] fo_hi;
	logic [31:0] fo_lo;
	logic [15:0] ref_adj;

	vcp_fixed_encoder u_bw_enc (
		.val_clk_unused_n (1'b0),
		.val              (bw_reg),
		.word_hi          (bw_hi),
		.word_lo          (bw_lo)
	);

	vcp_fixed_encoder u_fo_enc (
		.val_clk_unused_n (1'b0),
		.val              (fo_reg),
		.word_hi          (fo_hi),
		.word_lo          (fo_lo)
	);

	vcp_time_counter #(
		.PS_PER_SEC (PS_PER_SEC),
		.PS_STEP    (64'(VCP_PS_PER_CLK))
	) u_time (
		.pclk      (pclk),
		.presetn   (presetn),
		.load_sec  (wr_go && paddr == VCP_OFS_UTC_SEC),
		.sec_value (pwdata),
		.now       (now)
	);

	// One wait state: pready is a flop so every bus answer is registered
	assign wr_go = psel && penable && pwrite && pready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && rd_err;
			if (psel && penable && !pready && !pwrite) begin
				prdata <= rd_data;
			end else begin
				prdata <= 32'h0;
			end
		end
	end

	// Read decode; unmapped offsets answer zero with an error
	always_comb begin
		rd_data = 32'h0;
		rd_err  = 1'b0;
		unique case (paddr)
			VCP_OFS_CTRL:    rd_data = {29'h0, channel_swap_flag, 2'h0};
			VCP_OFS_STATUS:  rd_data = {8'h0, ext_cnt_reg, dig_cnt_reg,
				7'h0, req_ext_reg, req_dig_reg, pend_bw_reg, pend_fo_reg,
				pend_rl_reg, pend_swap_reg, stream_start_flag,
				sweep_start_flag, state_reg == VCP_SEND};
			VCP_OFS_BW_LO:   rd_data = bw_reg.int_hz[31:0];
			VCP_OFS_BW_HI:   rd_data = {20'h0, bw_reg.int_hz[43:32]};
			VCP_OFS_BW_FRAC: rd_data = {12'h0, bw_reg.frac};
			VCP_OFS_FO_LO:   rd_data = fo_reg.int_hz[31:0];
			VCP_OFS_FO_HI:   rd_data = {20'h0, fo_reg.int_hz[43:32]};
			VCP_OFS_FO_FRAC: rd_data = {12'h0, fo_reg.frac};
			VCP_OFS_REF:     rd_data = {VCP_REF_RSVD, ref_nom_reg};
			VCP_OFS_STREAM:  rd_data = stream_id_reg;
			VCP_OFS_SWEEP:   rd_data = sweep_id_reg;
			VCP_OFS_UTC_SEC: rd_data = now.seconds;
			default:         rd_err  = 1'b1;
		endcase
	end

	// Context values written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bw_reg            <= '0;
			fo_reg            <= '0;
			ref_nom_reg       <= 16'h0;
			stream_id_reg     <= 32'h0;
			sweep_id_reg      <= 32'h0;
			channel_swap_flag <= 1'b0;
		end else if (wr_go) begin
			unique case (paddr)
				VCP_OFS_CTRL:    channel_swap_flag <= pwdata[VCP_CTRL_SWAP];
				VCP_OFS_BW_LO:   bw_reg.int_hz[31:0]  <= pwdata;
				VCP_OFS_BW_HI:   bw_reg.int_hz[43:32] <= pwdata[11:0];
				VCP_OFS_BW_FRAC: bw_reg.frac          <= pwdata[19:0];
				VCP_OFS_FO_LO:   fo_reg.int_hz[31:0]  <= pwdata;
				VCP_OFS_FO_HI:   fo_reg.int_hz[43:32] <= pwdata[11:0];
				VCP_OFS_FO_FRAC: fo_reg.frac          <= pwdata[19:0];
				VCP_OFS_REF:     ref_nom_reg   <= pwdata[15:0];
				VCP_OFS_STREAM:  stream_id_reg <= pwdata;       // RQ19
				VCP_OFS_SWEEP:   sweep_id_reg  <= pwdata;       // RQ19
				default:         ;
			endcase
		end
	end

	// Gain history; a gain step alone also marks the reference level dirty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_prev_reg <= 16'h0;
		end else begin
			gain_prev_reg <= rfe_gain;
		end
	end

	// Pending flags: clear on the packet that carries them, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_dig_reg       <= 1'b0;
			req_ext_reg       <= 1'b0;
			pend_bw_reg       <= 1'b0;
			pend_fo_reg       <= 1'b0;
			pend_rl_reg       <= 1'b0;
			pend_swap_reg     <= 1'b0;
			stream_start_flag <= 1'b0;
			sweep_start_flag  <= 1'b0;
		end else begin
			if (start && sel_dig) begin
				req_dig_reg <= 1'b0;
				pend_bw_reg <= 1'b0;
				pend_fo_reg <= 1'b0;
				pend_rl_reg <= 1'b0;
			end
			if (start && !sel_dig) begin
				req_ext_reg       <= 1'b0;
				pend_swap_reg     <= 1'b0;
				stream_start_flag <= 1'b0;
				sweep_start_flag  <= 1'b0;
			end
			if (rfe_gain != gain_prev_reg) begin
				pend_rl_reg <= 1'b1;                          // RQ1
			end
			if (wr_go) begin
				unique case (paddr)
					VCP_OFS_CTRL: begin
						if (pwdata[VCP_CTRL_DIG]) req_dig_reg <= 1'b1;
						if (pwdata[VCP_CTRL_EXT]) req_ext_reg <= 1'b1;
						if (pwdata[VCP_CTRL_SWAP] != channel_swap_flag) begin
							pend_swap_reg <= 1'b1;                // RQ1
						end
					end
					VCP_OFS_BW_LO, VCP_OFS_BW_HI, VCP_OFS_BW_FRAC:
						pend_bw_reg <= 1'b1;                      // RQ1
					VCP_OFS_FO_LO, VCP_OFS_FO_HI, VCP_OFS_FO_FRAC:
						pend_fo_reg <= 1'b1;                      // RQ1
					VCP_OFS_REF:    pend_rl_reg       <= 1'b1;
					VCP_OFS_STREAM: stream_start_flag <= 1'b1;
					VCP_OFS_SWEEP:  sweep_start_flag  <= 1'b1;
					default:        ;
				endcase
			end
		end
	end

	// Reported level drops by the front-end gain, both in 1/128 units
	assign ref_adj = ref_nom_reg - rfe_gain;                  // RQ6 RQ5

	// Digitizer first; waiting for the last word to leave keeps a gap cycle
	assign sel_dig = req_dig_reg;
	assign start   = state_reg == VCP_IDLE && !tx_valid &&
		(req_dig_reg || req_ext_reg);

	// Assemble the whole packet in one go; fields follow indicator order
	always_comb begin
		logic [3:0]  n;
		logic [31:0] ind;
		n   = VCP_FIXED_WORDS;
		ind = 32'h0;
		for (int i = 0; i < VCP_MAX_WORDS; i++) begin
			build_words[i] = 32'h0;
		end
		build_words[2] = now.seconds;                         // RQ15
		build_words[3] = now.picos[63:32];
		build_words[4] = now.picos[31:0];
		if (sel_dig) begin
			build_words[1] = DIG_STREAM_ID;
			ind[VCP_IND_CHANGE] = pend_bw_reg || pend_fo_reg || pend_rl_reg;
			ind[VCP_IND_BW] = pend_bw_reg;
			ind[VCP_IND_FO] = pend_fo_reg;
			ind[VCP_IND_RL] = pend_rl_reg;
			if (pend_bw_reg) begin                            // RQ23
				build_words[n] = bw_hi;
				build_words[n + 4'h1] = bw_lo;
				n = n + 4'h2;
			end
			if (pend_fo_reg) begin                            // RQ7
				build_words[n] = fo_hi;
				build_words[n + 4'h1] = fo_lo;
				n = n + 4'h2;
			end
			if (pend_rl_reg) begin                            // RQ4
				build_words[n] = {VCP_REF_RSVD, ref_adj};
				n = n + 4'h1;
			end
			build_words[0] = vcp_pack_header(VCP_TYPE_DIG,   // RQ21
				dig_cnt_reg, {12'h0, n});
		end else begin
			build_words[1] = VCP_EXT_SID;                     // RQ12
			ind[VCP_IND_CHANGE] = pend_swap_reg || stream_start_flag ||
				sweep_start_flag;                              // RQ16
			ind[VCP_IND_SWAP]   = channel_swap_flag;          // RQ18
			ind[VCP_IND_STREAM] = stream_start_flag;
			ind[VCP_IND_SWEEP]  = sweep_start_flag;
			if (stream_start_flag) begin                      // RQ17
				build_words[n] = stream_id_reg;
				n = n + 4'h1;
			end
			if (sweep_start_flag) begin
				build_words[n] = sweep_id_reg;
				n = n + 4'h1;
			end
			build_words[0] = vcp_pack_header(VCP_TYPE_EXT,   // RQ8 RQ9 RQ22
				ext_cnt_reg, {12'h0, n});                       // RQ11
		end
		build_words[5] = ind;
		build_len      = n;
	end

	// Snapshot memory; no reset needed, it is read only after a start
	always_ff @(posedge pclk) begin
		if (start) begin
			pkt_mem <= build_words;
		end
	end

	// Sequencer and word output; tx_data[31:24] is the first byte on wire
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= VCP_IDLE;
			idx_reg     <= 4'h0;
			len_reg     <= 4'h0;
			dig_cnt_reg <= 4'h0;
			ext_cnt_reg <= 4'h0;
			tx_data     <= 32'h0;
			tx_valid    <= 1'b0;
			tx_last     <= 1'b0;
		end else begin
			unique case (state_reg)
				VCP_IDLE: begin
					if (tx_ready) begin
						tx_valid <= 1'b0;
						tx_last  <= 1'b0;
					end
					if (start) begin
						len_reg   <= build_len;
						idx_reg   <= 4'h0;
						state_reg <= VCP_SEND;
						if (sel_dig) begin
							dig_cnt_reg <= dig_cnt_reg + 4'h1;       // RQ10
						end else begin
							ext_cnt_reg <= ext_cnt_reg + 4'h1;       // RQ10
						end
					end
				end
				VCP_SEND: begin
					if (!tx_valid || tx_ready) begin
						tx_data  <= pkt_mem[idx_reg];                // RQ20
						tx_valid <= 1'b1;
						tx_last  <= idx_reg == len_reg - 4'h1;
						if (idx_reg == len_reg - 4'h1) begin
							state_reg <= VCP_IDLE;
						end else begin
							idx_reg <= idx_reg + 4'h1;
						end
					end
				end
			endcase
		end
	end

endmodule // vcp_builder

// File: hdl/vcp_fixed_encoder.sv
`timescale 1ns/10ps
module vcp_fixed_encoder (
	input  wire logic              val_clk_unused_n,
	input  wire vcp_pkg::vcp_fix64_t val,
	output logic [31:0]            word_hi,
	output logic [31:0]            word_lo
);
	import vcp_pkg::*;

	// Integer bits 43:12 lead; the low word holds int 11:0 over the fraction
	assign word_hi = val.int_hz[43:12];                   // RQ3
	assign word_lo = {val.int_hz[11:0], val.frac};        // RQ2

endmodule // vcp_fixed_encoder

// File: hdl/vcp_time_counter.sv
`timescale 1ns/10ps
module vcp_time_counter #(
	parameter logic [63:0] PS_PER_SEC = vcp_pkg::VCP_PS_PER_SEC,
	parameter logic [63:0] PS_STEP    = 64'(vcp_pkg::VCP_PS_PER_CLK)
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              load_sec,
	input  wire logic [31:0]       sec_value,
	output vcp_pkg::vcp_time_t     now
);
	import vcp_pkg::*;

	logic [63:0] pico_sum;

	assign pico_sum = now.picos + PS_STEP;

	// Seconds advance on the picosecond wrap; remainder keeps long-term rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			now <= '0;
		end else if (load_sec) begin
			now.seconds <= sec_value;                     // RQ13
			now.picos   <= 64'h0;
		end else if (pico_sum >= PS_PER_SEC) begin
			now.seconds <= now.seconds + 32'h1;
			now.picos   <= pico_sum - PS_PER_SEC;         // RQ14
		end else begin
			now.picos   <= pico_sum;
		end
	end

endmodule // vcp_time_counter

// File: include/vcp_pkg.sv
// Function
// RQ1: Change bit plus each changed field's bit.
// RQ2: Bandwidth is 64-bit signed fixed-point hertz.
// RQ3: Bandwidth integer and fraction split across words.
// RQ4: Reference level: zero upper half, signed lower.
// RQ5: Reference level LSB is 1/128 dBm.
// RQ6: Reference level adjusted by front-end gain.
// RQ7: Frequency offset uses bandwidth's fixed-point format.
// RQ8: Extension header type 0101, flags zero.
// RQ9: Timestamp codes: UTC seconds, picosecond fraction.
// RQ10: Four-bit packet counter wraps to zero.
// RQ11: Size field counts every word sent.
// RQ12: Extension stream identifier fixed after header.
// RQ13: Seconds word counts UTC seconds since 1970.
// RQ14: Picoseconds restart when seconds advance.
// RQ15: Header, id, seconds, picoseconds, indicator, fields.
// RQ16: Extension indicator bits 31, 3, 1, 0.
// RQ17: Fields follow indicator bit order.
// RQ18: Swap bit set when converter channels exchanged.
// RQ19: Start identifiers are 32-bit unsigned words.
// RQ20: Words leave most significant byte first.
// RQ21: Digitizer context packets use type 0100.
// RQ22: Header word bit layout fixed.
// RQ23: Digitizer fields sent only when flagged.
package vcp_pkg;

	// Clock and timestamp timing
	localparam int          VCP_CLK_MHZ      = 250;
	localparam int          VCP_PS_PER_CLK   = 1000000 / VCP_CLK_MHZ;
	localparam logic [63:0] VCP_PS_PER_SEC   = 64'h0000_00E8_D4A5_1000;

	// Register byte offsets
	localparam int          VCP_ADDR_W       = 8;
	localparam logic [7:0]  VCP_OFS_CTRL     = 8'h00;
	localparam logic [7:0]  VCP_OFS_STATUS   = 8'h04;
	localparam logic [7:0]  VCP_OFS_BW_LO    = 8'h08;
	localparam logic [7:0]  VCP_OFS_BW_HI    = 8'h0C;
	localparam logic [7:0]  VCP_OFS_BW_FRAC  = 8'h10;
	localparam logic [7:0]  VCP_OFS_FO_LO    = 8'h14;
	localparam logic [7:0]  VCP_OFS_FO_HI    = 8'h18;
	localparam logic [7:0]  VCP_OFS_FO_FRAC  = 8'h1C;
	localparam logic [7:0]  VCP_OFS_REF      = 8'h20;
	localparam logic [7:0]  VCP_OFS_STREAM   = 8'h24;
	localparam logic [7:0]  VCP_OFS_SWEEP    = 8'h28;
	localparam logic [7:0]  VCP_OFS_UTC_SEC  = 8'h2C;

	// Control register fields
	localparam int          VCP_CTRL_DIG     = 0;
	localparam int          VCP_CTRL_EXT     = 1;
	localparam int          VCP_CTRL_SWAP    = 2;

	// Header field values
	localparam logic [3:0]  VCP_TYPE_DIG     = 4'h4;
	localparam logic [3:0]  VCP_TYPE_EXT     = 4'h5;
	localparam logic [1:0]  VCP_TSI_UTC      = 2'h1;
	localparam logic [1:0]  VCP_TSF_PICO     = 2'h2;
	localparam logic [31:0] VCP_EXT_SID      = 32'h9000_0004;
	localparam logic [31:0] VCP_DIG_SID_DEF  = 32'h9000_0002;

	// Indicator bit positions
	localparam int          VCP_IND_CHANGE   = 31;
	localparam int          VCP_IND_BW       = 29;
	localparam int          VCP_IND_FO       = 26;
	localparam int          VCP_IND_RL       = 24;
	localparam int          VCP_IND_SWAP     = 3;
	localparam int          VCP_IND_STREAM   = 1;
	localparam int          VCP_IND_SWEEP    = 0;

	// Packet sizing
	localparam logic [3:0]  VCP_FIXED_WORDS  = 4'h6;
	localparam int          VCP_MAX_WORDS    = 11;
	localparam logic [15:0] VCP_REF_RSVD     = 16'h0000;

	typedef struct packed {
		logic [3:0]  pkt_type;
		logic        class_flag;
		logic [1:0]  rsvd;
		logic        tsm;
		logic [1:0]  tsi;
		logic [1:0]  tsf;
		logic [3:0]  count;
		logic [15:0] size;
	} vcp_header_t;

	typedef struct packed {
		logic [43:0] int_hz;
		logic [19:0] frac;
	} vcp_fix64_t;

	typedef struct packed {
		logic [31:0] seconds;
		logic [63:0] picos;
	} vcp_time_t;

	typedef enum logic [0:0] {
		VCP_IDLE = 1'b0,
		VCP_SEND = 1'b1
	} vcp_state_t;

	// Header layout shared by both packet classes
	function automatic logic [31:0] vcp_pack_header(
		input logic [3:0]  t,
		input logic [3:0]  c,
		input logic [15:0] s);
		vcp_header_t h;
		h.pkt_type   = t;
		h.class_flag = 1'b0;
		h.rsvd       = 2'h0;
		h.tsm        = 1'b0;
		h.tsi        = VCP_TSI_UTC;
		h.tsf        = VCP_TSF_PICO;
		h.count      = c;
		h.size       = s;
		return h;
	endfunction

endpackage

// File: testbench/vcp_builder_monitor.sv
`timescale 1ns/10ps
module vcp_builder_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] tx_data,
	input wire logic        tx_valid,
	input wire logic        tx_last,
	input wire logic        tx_ready
);
	import vcp_pkg::*;
	logic [3:0]  idx;
	logic [3:0]  typ;
	logic [15:0] sz;
	wire         acc = tx_valid && tx_ready;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Word position, type and size of the packet on the stream
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx <= 4'h0;
			typ <= 4'h0;
			sz  <= 16'h0;
		end else if (acc) begin
			idx <= tx_last ? 4'h0 : idx + 4'h1;
			if (idx == 4'h0) begin
				typ <= tx_data[31:28];
				sz  <= tx_data[15:0];
			end
		end
	end
	a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready stuck");
	a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error answer");
	a_idle_data: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata outside answer");
	a_word_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("word changed while stalled");
	a_hdr_fixed: assert property (tx_valid && idx == 4'h0 |->
		tx_data[27:20] == 8'h06 && tx_data[31:29] == 3'b010)
		else $error("header fixed bits wrong");
	a_ext_sid: assert property (tx_valid && idx == 4'h1 &&
		typ == 4'h5 |-> tx_data == 32'h9000_0004)
		else $error("extension stream id wrong");
	a_size_words: assert property (tx_valid && tx_last |->
		sz == 16'(idx) + 16'h1)
		else $error("size field disagrees with words");
	a_ext_ind: assert property (
		tx_valid && idx == 4'h5 && typ == 4'h5 |->
		tx_data[30:4] == 27'h0 && !tx_data[2] &&
		(tx_data[31] || tx_data[1:0] == 2'b00))
		else $error("extension indicator wrong");
	a_pkt_gap: assert property (acc && tx_last |=> !tx_valid)
		else $error("no idle cycle between packets");
	c_ext_pkt: cover property (acc && tx_last && typ == 4'h5);
	c_dig_pkt: cover property (acc && tx_last && typ == 4'h4);
	c_stall: cover property (tx_valid && !tx_ready);
	c_err: cover property (pslverr);
endmodule // vcp_builder_monitor

bind vcp_builder vcp_builder_monitor vcp_builder_monitor_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
	.tx_ready(tx_ready));

// File: testbench/vcp_builder_tb.sv
`timescale 1ns/10ps
module vcp_builder_tb;
	import vcp_pkg::*;
	typedef struct packed {
		logic [15:0] nom;
		logic [15:0] gain;
		logic [31:0] ref_word;
	} vcp_row_t;
	logic        pclk     = 1'b0;
	logic        presetn  = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [31:0] pwdata   = 32'h0;
	logic [15:0] rfe_gain = 16'h0;
	logic        stall    = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] tx_data;
	logic        tx_valid;
	logic        tx_last;
	logic        tx_ready;
	logic [31:0] rd;
	logic        er;
	int          error_cnt = 0;
	int          n_checks  = 0;
	// Nominal level, gain, expected word: +1, -1 and -1/128 dBm
	vcp_row_t    rows [3] = '{'{16'h0080, 16'h0000, 32'h0000_0080},
		'{16'h0000, 16'h0080, 32'h0000_FF80},
		'{16'h0001, 16'h0002, 32'h0000_FFFF}};

	// Short second so the seconds roll over inside the extension test
	vcp_builder #(.PS_PER_SEC(64'h0000_0000_0000_9C40)) vcp_builder_inst (
		.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rfe_gain(rfe_gain), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));
	vcp_sink_model vcp_sink_model_inst (.pclk(pclk), .presetn(presetn),
		.stall(stall), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_last(tx_last), .tx_ready(tx_ready));

	always #2 pclk = ~pclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// Setup, access, hold until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (t >= 50)
			chk(32'h0, 32'h1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// Wait until the host has taken the last word of one more packet
	task automatic wait_pkt(input int p);
		int t;
		t = 0;
		while (vcp_sink_model_inst.pkts == p && t < 400) begin
			@(posedge pclk);
			t++;
		end
		if (t >= 400)
			chk(32'h0, 32'h1);
	endtask

	task automatic pkt(input logic [31:0] c);
		int p;
		p = vcp_sink_model_inst.pkts;
		wr(VCP_OFS_CTRL, c);
		wait_pkt(p);
	endtask

	function automatic logic [31:0] wd(input int i);
		return vcp_sink_model_inst.w[i];
	endfunction

	// C, reserved and TSM zero, TSI 01, TSF 10
	function automatic logic [31:0] hdr(input logic [3:0] t,
		input logic [3:0] c, input logic [15:0] s);
		return {t, 8'h06, c, s};
	endfunction

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog well beyond the several hundred cycles the tests need
	initial begin
		#100000;
		error_cnt++;
		give_verdict();
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			wr(VCP_OFS_REF, {16'h0, rows[i].nom});
			rfe_gain <= rows[i].gain;
			pkt(32'h1);
			chk(wd(0), hdr(4'h4, 4'(i), 16'h7));
			chk(wd(5), 32'h8100_0000);
			chk(wd(6), rows[i].ref_word);
		end
		$display("test ref_rows done");
		stall <= 1'b1;
		wr(VCP_OFS_BW_LO, 32'h89AB_CDEF);
		wr(VCP_OFS_BW_HI, 32'h0000_0123);
		wr(VCP_OFS_BW_FRAC, 32'h000A_5A5A);
		wr(VCP_OFS_FO_LO, 32'hFFFF_FFFE);
		wr(VCP_OFS_FO_HI, 32'h0000_0FFF);
		wr(VCP_OFS_FO_FRAC, 32'h0008_0000);
		pkt(32'h1);
		chk(wd(0), hdr(4'h4, 4'h3, 16'hA));
		chk(wd(5), 32'hA400_0000);
		chk(wd(6), 32'h1238_9ABC);
		chk(wd(7), 32'hDEFA_5A5A);
		chk(wd(8), 32'hFFFF_FFFF);
		chk(wd(9), 32'hFFE8_0000);
		$display("test fixed_point done");
		wr(VCP_OFS_UTC_SEC, 32'h5E0B_E100);
		wr(VCP_OFS_CTRL, 32'h4);
		wr(VCP_OFS_STREAM, 32'h0000_0007);
		wr(VCP_OFS_SWEEP, 32'h0000_0042);
		pkt(32'h6);
		chk(wd(0), hdr(4'h5, 4'h0, 16'h8));
		chk(wd(1), 32'h9000_0004);
		// Start 17 edges after the load: one second of 10 steps, then 6 more
		chk(wd(2), 32'h5E0B_E101);
		chk(wd(3), 32'h0);
		chk(wd(4), 32'h0000_5DC0);
		chk(wd(5), 32'h8000_000B);
		chk(wd(6), 32'h0000_0007);
		chk(wd(7), 32'h0000_0042);
		pkt(32'h6);
		chk(wd(0), hdr(4'h5, 4'h1, 16'h6));
		chk(wd(5), 32'h0000_0008);
		for (int k = 2; k < 18; k++) begin
			pkt(32'h6);
			chk(wd(0), hdr(4'h5, 4'(k), 16'h6));
		end
		$display("test extension done");
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, 8'h7C, 32'hFFFF_FFFF);
		chk({31'h0, er}, 32'h1);
		$display("test unmapped done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		chk({31'h0, tx_valid}, 32'h0);
		pkt(32'h2);
		chk(wd(0), hdr(4'h5, 4'h0, 16'h6));
		chk(wd(5), 32'h0);
		$display("test reset done");
		// Both requests at once: digitizer first, extension after a gap
		pkt(32'h3);
		chk(wd(0), hdr(4'h4, 4'h0, 16'h7));
		chk(wd(5), 32'h8100_0000);
		chk(wd(6), 32'h0000_FFFE);
		wait_pkt(vcp_sink_model_inst.pkts);
		chk(wd(0), hdr(4'h5, 4'h1, 16'h6));
		chk(wd(5), 32'h0);
		apb(1'b0, VCP_OFS_STATUS, 32'h0);
		chk({31'h0, er}, 32'h0);
		chk(rd, 32'h0021_0000);
		$display("test priority done");
		give_verdict();
	end
endmodule // vcp_builder_tb

// File: testbench/vcp_sink_model.sv
`timescale 1ns/10ps
module vcp_sink_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        stall,
	input  wire logic [31:0] tx_data,
	input  wire logic        tx_valid,
	input  wire logic        tx_last,
	output logic             tx_ready
);
	logic [31:0] w [0:15];
	int          n;
	int          pkts;
	logic [1:0]  ph;
	// Host refuses two cycles in three while stalling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph       <= 2'h0;
			tx_ready <= 1'b0;
		end else begin
			ph       <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
			tx_ready <= !stall || ph == 2'h0;
		end
	end
	// Words kept whole, first byte in bits 31:24
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n    <= 0;
			pkts <= 0;
		end else if (tx_valid && tx_ready) begin
			w[n[3:0]] <= tx_data;
			n         <= tx_last ? 0 : n + 1;
			if (tx_last)
				pkts <= pkts + 1;
		end
	end
endmodule // vcp_sink_model
